// ### hdl/counter_prescaler.sv
// Auto-reloading up-counter with selectable prescaler
`default_nettype none
module counter_prescaler
    import ptiu_pkg::*;
#(
    parameter int CW = CNT_W,
    parameter int PW = PRESC_W
)(
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic [MODE_W-1:0] i_mode,
    input  wire logic              i_load,
    input  wire logic [CW-1:0]     i_reload,
    output logic      [CW-1:0]     o_count,
    output logic                   o_overflow
);
    logic [PW-1:0] presc_reg;
    logic [PW-1:0] mask;
    logic          tick;

    // Low bits that must all be set for a counter tick
    function automatic logic [PW-1:0] tick_mask(input logic [MODE_W-1:0] mode);
        tick_mask = PW'((1 << PRESC_SHIFT[mode]) - 1);
    endfunction

    assign mask = tick_mask(i_mode);
    assign tick = (presc_reg & mask) == mask;

    ////////////////////////////////////////////////////////////////////////
    // Free-running prescaler on the system clock
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            presc_reg <= '0;
        else
            presc_reg <= presc_reg + 1'b1;
    end

    // Counter: load on high write, reload on rollover
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            o_count <= '0;
        else if (i_load)
            o_count <= i_reload;
        else if (tick && o_count == '1)
            o_count <= i_reload;
        else if (tick)
            o_count <= o_count + 1'b1;
    end

    // One-cycle overflow strobe
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            o_overflow <= 1'b0;
        else
            o_overflow <= tick && !i_load && o_count == '1;
    end
endmodule // counter_prescaler
`default_nettype wire

// ### hdl/port_pins.sv
// Pad drivers, pull-ups, input synchronisers and falling-edge detect
`default_nettype none
module port_pins
    import ptiu_pkg::*;
#(
    parameter int NP = NUM_PINS,
    parameter int EP = EDGE_PIN
)(
    input  wire logic          i_clk,
    input  wire logic          i_reset,
    input  wire logic [NP-1:0] i_dir,
    input  wire logic [NP-1:0] i_latch,
    input  wire logic [NP-1:0] i_pull,
    input  wire logic [NP-1:0] i_analog,
    input  wire logic [NP-1:0] i_pad_in,
    output logic      [NP-1:0] o_pad_out,
    output logic      [NP-1:0] o_pad_oe,
    output logic      [NP-1:0] o_pull_en,
    output logic      [NP-1:0] o_level,
    output logic               o_fall
);
    logic [NP-1:0] sync1_reg;
    logic          edge_prev_reg;

    genvar g;
    generate
        for (g = 0; g < NP; g++)
        begin : g_pin
            if (g == EP)
            begin : g_od
                // Open-drain: only pulls low, no pull-up
                always_ff @(posedge i_clk)
                begin
                    if (i_reset)
                    begin
                        o_pad_out[g] <= 1'b0;
                        o_pad_oe[g]  <= 1'b0;
                        o_pull_en[g] <= 1'b0;
                    end
                    else
                    begin
                        o_pad_out[g] <= 1'b0;
                        o_pad_oe[g]  <= i_dir[g] && !i_latch[g];
                        o_pull_en[g] <= 1'b0;
                    end
                end
            end
            else
            begin : g_cmos
                // Push-pull with pull-up off when output or analog
                always_ff @(posedge i_clk)
                begin
                    if (i_reset)
                    begin
                        o_pad_out[g] <= 1'b0;
                        o_pad_oe[g]  <= 1'b0;
                        o_pull_en[g] <= 1'b0;
                    end
                    else
                    begin
                        o_pad_out[g] <= i_latch[g];
                        o_pad_oe[g]  <= i_dir[g] && !i_analog[g];
                        o_pull_en[g] <= i_pull[g] && !i_dir[g] && !i_analog[g];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser for pad levels
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            sync1_reg <= '0;
            o_level   <= '0;
        end
        else
        begin
            sync1_reg <= i_pad_in;
            o_level   <= sync1_reg;
        end
    end

    // Falling edge on the interrupt pin as digital input only
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            edge_prev_reg <= 1'b0;
            o_fall        <= 1'b0;
        end
        else
        begin
            edge_prev_reg <= o_level[EP];
            o_fall        <= edge_prev_reg && !o_level[EP] && !i_dir[EP] && !i_analog[EP];
        end
    end
endmodule // port_pins
`default_nettype wire

// ### hdl/port_timer_interrupt_unit.sv
// Port, timer and interrupt peripheral cluster of a 4-bit controller
`default_nettype none
// Summary of operation
// - Direction bit 1 output, 0 input, resets 0
// - Pull-up bit 1 enables input pull-up
// - Output pins always have pull-up off
// - Interrupt pin: open drain, no pull-up
// - Output latch drives pad when output and not analog
// - Read returns latch if output, pad if input
// - Falling edge on interrupt pin as digital input sets request
// - Analog pins never raise port requests
// - Port interrupt wakes from HALT and STOP
// - 8-bit up-counter reloads on overflow
// - Rollover from FF to the reload value sets timer request
// - High nibble write loads whole counter
// - Low write then high; high read first
// - Mode selects prescale 2^11 down to 2^0
// - System clock is oscillator over sixteen
// - Enable and request: push PC, jump
// - Vectors 000 reset, 001, 002, 004
// - Service entry clears all enable flags
// - Service after two instructions, cancel if cleared
// - Enable bit 3 gates conversion-done source
// - Timer and conversion wake from HALT
// - Every reset clears enable and request flags
// - Watchdog reset keeps mode; ports clear
// - Any reset restarts program counter at zero
module port_timer_interrupt_unit
    import ptiu_pkg::*;
#(
    parameter int NP = NUM_PINS
)(
    input  wire logic            i_clk,
    input  wire logic            i_reset,
    input  wire logic            i_wdt_reset,
    input  wire reg_req_t        i_req,
    output logic     [NIB_W-1:0] o_reg_rdata,
    input  wire logic            i_instr_done,
    input  wire logic            i_conv_done,
    input  wire logic [3:0]      i_analog_sel,
    input  wire logic [NP-1:0]   i_pad_in,
    output logic      [NP-1:0]   o_pad_out,
    output logic      [NP-1:0]   o_pad_oe,
    output logic      [NP-1:0]   o_pullup_en,
    output logic                 o_irq_take,
    output logic      [PC_W-1:0] o_irq_vector,
    output logic                 o_pc_restart,
    output logic                 o_wake_halt,
    output logic                 o_wake_stop
);
    logic              any_reset;
    logic [NIB_W-1:0]  irq_enable_flags_reg;
    logic [NIB_W-1:0]  irq_request_flags_reg;
    logic [NIB_W-1:0]  irq_request_flags_next;
    logic [MODE_W-1:0] counter_prescale_select_reg;
    logic [NIB_W-1:0]  reload_low_nibble_reg;
    logic [NIB_W-1:0]  reload_high_nibble_reg;
    logic [CNT_W-1:0]  reload_value;
    logic [NIB_W-1:0]  count_value_low_reg;
    logic [NIB_W-1:0]  first_port_data_reg;
    logic [1:0]        second_port_data_reg;
    logic [NIB_W-1:0]  first_port_direction_reg;
    logic [1:0]        second_port_direction_reg;
    logic [2:0]        first_port_pullup_reg;
    logic [1:0]        second_port_pullup_reg;
    logic [1:0]        instr_cnt_reg;
    logic [NIB_W-1:0]  pending;
    logic              take;
    logic [PC_W-1:0]   take_vector;
    logic              load_now;
    logic [CNT_W-1:0]  count;
    logic              overflow;
    logic              pin_fall;
    logic [NP-1:0]     dir_all;
    logic [NP-1:0]     latch_all;
    logic [NP-1:0]     pull_all;
    logic [NP-1:0]     analog_all;
    logic [NP-1:0]     level;
    logic [NP-1:0]     pin_read;
    logic [NIB_W-1:0]  rdata_next;

    // Register write strobe for one address
    function automatic logic wr_hit(input reg_req_t req, input logic [ADDR_W-1:0] a);
        wr_hit = req.wr && req.addr == a;
    endfunction

    assign any_reset = i_reset || i_wdt_reset;

    ////////////////////////////////////////////////////////////////////////
    // Pin vectors: port A in bits 3..0, port B in bits 5..4
    assign dir_all    = {second_port_direction_reg, first_port_direction_reg};
    assign latch_all  = {second_port_data_reg, first_port_data_reg};
    assign pull_all   = {second_port_pullup_reg, 1'b0, first_port_pullup_reg};
    assign analog_all = {1'b0, i_analog_sel[3], 1'b0, i_analog_sel[2:0]};
    assign pin_read   = (dir_all & latch_all) | (~dir_all & level);

    port_pins #(
        .NP (NP),
        .EP (EDGE_PIN)
    ) u_pins (
        .i_clk     (i_clk),
        .i_reset   (any_reset),
        .i_dir     (dir_all),
        .i_latch   (latch_all),
        .i_pull    (pull_all),
        .i_analog  (analog_all),
        .i_pad_in  (i_pad_in),
        .o_pad_out (o_pad_out),
        .o_pad_oe  (o_pad_oe),
        .o_pull_en (o_pullup_en),
        .o_level   (level),
        .o_fall    (pin_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Timer: high-nibble write loads the whole counter
    assign load_now = wr_hit(i_req, ADDR_CNT_HI);

    // Whole load value; the high write feeds the counter at once
    assign reload_value = load_now ? {i_req.wdata, reload_low_nibble_reg}
                                   : {reload_high_nibble_reg, reload_low_nibble_reg};

    counter_prescaler #(
        .CW (CNT_W),
        .PW (PRESC_W)
    ) u_timer (
        .i_clk      (i_clk),
        .i_reset    (any_reset),
        .i_mode     (counter_prescale_select_reg),
        .i_load     (load_now),
        .i_reload   (reload_value),
        .o_count    (count),
        .o_overflow (overflow)
    );

    // Low load nibble waits for the high write
    always_ff @(posedge i_clk)
    begin
        if (any_reset)
            reload_low_nibble_reg <= NIB_ZERO;
        else if (wr_hit(i_req, ADDR_CNT_LO))
            reload_low_nibble_reg <= i_req.wdata;
    end

    // High load nibble kept for the automatic reload
    always_ff @(posedge i_clk)
    begin
        if (any_reset)
            reload_high_nibble_reg <= NIB_ZERO;
        else if (load_now)
            reload_high_nibble_reg <= i_req.wdata;
    end

    // Mode kept over watchdog reset
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            counter_prescale_select_reg <= MODE_RESET;
        else if (!i_wdt_reset && wr_hit(i_req, ADDR_MODE))
            counter_prescale_select_reg <= i_req.wdata[MODE_W-1:0];
    end

    // High read snapshots the low count nibble
    always_ff @(posedge i_clk)
    begin
        if (any_reset)
            count_value_low_reg <= NIB_ZERO;
        else if (i_req.rd && i_req.addr == ADDR_CNT_HI)
            count_value_low_reg <= count[NIB_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Port data, direction and pull-up registers
    always_ff @(posedge i_clk)
    begin
        if (any_reset)
        begin
            first_port_data_reg       <= NIB_ZERO;
            second_port_data_reg      <= '0;
            first_port_direction_reg  <= NIB_ZERO;
            second_port_direction_reg <= '0;
            first_port_pullup_reg     <= '0;
            second_port_pullup_reg    <= '0;
        end
        else
        begin
            if (wr_hit(i_req, ADDR_PA))
                first_port_data_reg <= i_req.wdata;
            if (wr_hit(i_req, ADDR_PB))
                second_port_data_reg <= i_req.wdata[1:0];
            if (wr_hit(i_req, ADDR_DIR_A))
                first_port_direction_reg <= i_req.wdata;
            if (wr_hit(i_req, ADDR_DIR_B))
                second_port_direction_reg <= i_req.wdata[1:0];
            if (wr_hit(i_req, ADDR_PULL_A))
                first_port_pullup_reg <= i_req.wdata[2:0];
            if (wr_hit(i_req, ADDR_PULL_B))
                second_port_pullup_reg <= i_req.wdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux, unimplemented bits as zero
    always_comb
    begin
        rdata_next = NIB_ZERO;
        case (i_req.addr)
            ADDR_IRQ_EN:  rdata_next = irq_enable_flags_reg;
            ADDR_IRQ_REQ: rdata_next = irq_request_flags_reg;
            ADDR_MODE:    rdata_next = {1'b0, counter_prescale_select_reg};
            ADDR_CNT_LO:  rdata_next = count_value_low_reg;
            ADDR_CNT_HI:  rdata_next = count[CNT_W-1:NIB_W];
            ADDR_PA:      rdata_next = pin_read[NIB_W-1:0];
            ADDR_PB:      rdata_next = {2'b00, pin_read[NP-1:NIB_W]};
            ADDR_DIR_A:   rdata_next = first_port_direction_reg;
            ADDR_DIR_B:   rdata_next = {2'b00, second_port_direction_reg};
            ADDR_PULL_A:  rdata_next = {1'b0, first_port_pullup_reg};
            ADDR_PULL_B:  rdata_next = {2'b00, second_port_pullup_reg};
            default:      rdata_next = NIB_ZERO;
        endcase
    end

    // Registered read data
    always_ff @(posedge i_clk)
    begin
        if (any_reset)
            o_reg_rdata <= NIB_ZERO;
        else if (i_req.rd)
            o_reg_rdata <= rdata_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt requests: hardware set wins over software clear
    always_comb
    begin
        irq_request_flags_next = irq_request_flags_reg;
        if (wr_hit(i_req, ADDR_IRQ_REQ))
            irq_request_flags_next = i_req.wdata & IRQ_IMPL;
        if (i_conv_done)
            irq_request_flags_next[BIT_CONV] = 1'b1;
        if (overflow)
            irq_request_flags_next[BIT_CNT] = 1'b1;
        if (pin_fall)
            irq_request_flags_next[BIT_PIN] = 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        if (any_reset)
            irq_request_flags_reg <= NIB_ZERO;
        else
            irq_request_flags_reg <= irq_request_flags_next;
    end

    // Enables: service entry clears them all
    always_ff @(posedge i_clk)
    begin
        if (any_reset)
            irq_enable_flags_reg <= NIB_ZERO;
        else if (take)
            irq_enable_flags_reg <= NIB_ZERO;
        else if (wr_hit(i_req, ADDR_IRQ_EN))
            irq_enable_flags_reg <= i_req.wdata & IRQ_IMPL;
    end

    assign pending = irq_enable_flags_reg & irq_request_flags_reg;

    // Retired-instruction count while something is pending
    always_ff @(posedge i_clk)
    begin
        if (any_reset || pending == NIB_ZERO || take)
            instr_cnt_reg <= '0;
        else if (i_instr_done && instr_cnt_reg != INSTR_DELAY)
            instr_cnt_reg <= instr_cnt_reg + 1'b1;
    end

    assign take = pending != NIB_ZERO && instr_cnt_reg == INSTR_DELAY;

    // Fixed priority vector selection
    always_comb
    begin
        if (pending[BIT_CONV])
            take_vector = VEC_CONV;
        else if (pending[BIT_CNT])
            take_vector = VEC_CNT;
        else
            take_vector = VEC_PIN;
    end

    // Service strobe, vector and restart to the core
    always_ff @(posedge i_clk)
    begin
        if (any_reset)
        begin
            o_irq_take   <= 1'b0;
            o_irq_vector <= VEC_RESET;
            o_pc_restart <= 1'b1;
        end
        else
        begin
            o_irq_take   <= take;
            o_pc_restart <= 1'b0;
            if (take)
                o_irq_vector <= take_vector;
        end
    end

    // Wake-up levels for the low-power modes
    always_ff @(posedge i_clk)
    begin
        if (any_reset)
        begin
            o_wake_halt <= 1'b0;
            o_wake_stop <= 1'b0;
        end
        else
        begin
            o_wake_halt <= pending != NIB_ZERO;
            o_wake_stop <= pending[BIT_PIN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (any_reset);

    a_entry_clears_en: assert property (o_irq_take |-> irq_enable_flags_reg == NIB_ZERO)
        else $error("enables not cleared on service entry");
    a_vector_priority: assert property (o_irq_take |-> o_irq_vector ==
        ($past(pending[BIT_CONV]) ? VEC_CONV : $past(pending[BIT_CNT]) ? VEC_CNT : VEC_PIN))
        else $error("wrong vector on service entry");
    a_take_after_two: assert property (o_irq_take |-> $past(instr_cnt_reg) == INSTR_DELAY)
        else $error("service began without two instructions");
    a_ovf_sets_req: assert property (overflow |=> irq_request_flags_reg[BIT_CNT])
        else $error("overflow did not set timer request");
    a_pull_off_out: assert property ((o_pullup_en & $past(dir_all)) == '0)
        else $error("pull-up on while pin is output");
    a_edge_no_pull: assert property (!o_pullup_en[EDGE_PIN] && !o_pad_out[EDGE_PIN])
        else $error("open-drain pin pulled or driven high");
    a_high_write_load: assert property (load_now |=> count == $past({i_req.wdata, reload_low_nibble_reg}))
        else $error("counter not loaded on high write");
    a_port_wake_stop: assert property (pending[BIT_PIN] |=> o_wake_stop && o_wake_halt)
        else $error("port request did not wake");
    a_fall_sets_req: assert property (pin_fall |=> irq_request_flags_reg[BIT_PIN])
        else $error("falling edge did not set port request");
    a_mode_kept_wdt: assert property (disable iff (i_reset)
        i_wdt_reset |=> counter_prescale_select_reg == $past(counter_prescale_select_reg))
        else $error("mode changed by watchdog reset");

    c_take_conv: cover property (o_irq_take && o_irq_vector == VEC_CONV);
    c_take_pin: cover property (o_irq_take && o_irq_vector == VEC_PIN);
    c_overflow: cover property (overflow);
    c_wake_stop: cover property (o_wake_stop);
endmodule // port_timer_interrupt_unit
`default_nettype wire

// ### hdl/ptiu_pkg.sv
// Constants and carriers shared by the port, timer and interrupt unit
`default_nettype none
package ptiu_pkg;
    localparam int NIB_W    = 4;
    localparam int ADDR_W   = 5;
    localparam int NUM_PINS = 6;
    localparam int PC_W     = 12;
    localparam int CNT_W    = 8;
    localparam int PRESC_W  = 11;
    localparam int MODE_W   = 3;
    localparam int EDGE_PIN = 3;

    // System register addresses
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN  = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_REQ = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_MODE    = 5'h02;
    localparam logic [ADDR_W-1:0] ADDR_CNT_LO  = 5'h03;
    localparam logic [ADDR_W-1:0] ADDR_CNT_HI  = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_PA      = 5'h05;
    localparam logic [ADDR_W-1:0] ADDR_PB      = 5'h06;
    localparam logic [ADDR_W-1:0] ADDR_DIR_A   = 5'h13;
    localparam logic [ADDR_W-1:0] ADDR_DIR_B   = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_PULL_A  = 5'h1b;
    localparam logic [ADDR_W-1:0] ADDR_PULL_B  = 5'h1c;

    // Interrupt flag bit positions and implemented-bit masks
    localparam int BIT_CONV = 3;
    localparam int BIT_CNT  = 2;
    localparam int BIT_PIN  = 0;
    localparam logic [NIB_W-1:0] IRQ_IMPL    = 4'hd;
    localparam logic [NIB_W-1:0] MODE_IMPL   = 4'h7;
    localparam logic [NIB_W-1:0] PB_IMPL     = 4'h3;
    localparam logic [NIB_W-1:0] PULL_A_IMPL = 4'h7;
    localparam logic [NIB_W-1:0] NIB_ZERO    = 4'h0;
    localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;

    // Fixed vectors
    localparam logic [PC_W-1:0] VEC_RESET = 12'h000;
    localparam logic [PC_W-1:0] VEC_CONV  = 12'h001;
    localparam logic [PC_W-1:0] VEC_CNT   = 12'h002;
    localparam logic [PC_W-1:0] VEC_PIN   = 12'h004;

    // Instructions retired between pending and service
    localparam logic [1:0] INSTR_DELAY = 2'h2;

    // Prescaler exponent per mode code 000..111
    localparam logic [3:0] PRESC_SHIFT [8] = '{4'hb, 4'h9, 4'h7, 4'h5, 4'h3, 4'h2, 4'h1, 4'h0};

    // Register access from the core
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [NIB_W-1:0]  wdata;
    } reg_req_t;
endpackage
`default_nettype wire

// ### sim/pin_world.sv
// Pad model: outside drivers, pull-ups, floating pads
`default_nettype none
module pin_world
(
    input  wire logic       i_clk,
    input  wire logic [5:0] i_oe,
    input  wire logic [5:0] i_out,
    input  wire logic [5:0] i_pull,
    input  wire logic [5:0] i_ext_en,
    input  wire logic [5:0] i_ext_val,
    output logic      [5:0] o_pad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip_reg = 1'b0;
    // Floating pads change every cycle
    always_ff @(posedge i_clk)
    begin
        flip_reg <= ~flip_reg;
    end
    // Chip drive first, then outside, then pull-up
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            o_pad[i] = i_oe[i] ? i_out[i] : i_ext_en[i] ? i_ext_val[i] : i_pull[i] | flip_reg;
        end
    end
endmodule // pin_world
`default_nettype wire

// ### sim/tb.sv
// Register-level bench for the port, timer and interrupt unit
`default_nettype none
module tb
    import ptiu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wdt_rst = 1'b0;
    logic        instr = 1'b0;
    logic        conv = 1'b0;
    reg_req_t    req = '0;
    logic [5:0]  ext_en = 6'h3f;
    logic [5:0]  ext_val = 6'h00;
    logic [3:0]  ana = 4'h0;
    logic [5:0]  pad, p_out, p_oe, p_pull;
    logic [3:0]  rdata;
    logic [11:0] vec, last_vec;
    logic        take, restart, w_halt, w_stop;
    int          n_fail = 0;
    int          tests_run = 0;
    int          takes = 0;
    int          cycles = 0;
    logic [4:0]  adl [12] = '{ADDR_IRQ_EN, ADDR_IRQ_REQ, ADDR_MODE, ADDR_CNT_HI, ADDR_CNT_LO, ADDR_PA,
                              ADDR_PB, ADDR_DIR_A, ADDR_DIR_B, ADDR_PULL_A, ADDR_PULL_B, 5'h07};
    // 100 MHz clock
    always #5 clk = ~clk;
    port_timer_interrupt_unit dut (.i_clk(clk), .i_reset(rst), .i_wdt_reset(wdt_rst), .i_req(req),
        .o_reg_rdata(rdata), .i_instr_done(instr), .i_conv_done(conv), .i_analog_sel(ana),
        .i_pad_in(pad), .o_pad_out(p_out), .o_pad_oe(p_oe), .o_pullup_en(p_pull), .o_irq_take(take),
        .o_irq_vector(vec), .o_pc_restart(restart), .o_wake_halt(w_halt), .o_wake_stop(w_stop));
    pin_world pins (.i_clk(clk), .i_oe(p_oe), .i_out(p_out), .i_pull(p_pull), .i_ext_en(ext_en),
        .i_ext_val(ext_val), .o_pad(pad));
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Service count, last vector, hang limit
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (take === 1'b1)
        begin
            takes <= takes + 1;
            last_vec <= vec;
        end
        if (cycles == 5000)
        begin
            n_fail = n_fail + 1;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [3:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [3:0] exp, input string nm);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 4'h0};
        @(posedge clk);
        req <= '0;
        #1 chk(nm, 12'(exp), 12'(rdata));
    endtask
    task automatic pulse_instr(input int n);
        repeat (n)
        begin
            @(posedge clk);
            instr <= 1'b1;
            @(posedge clk);
            instr <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic hit_reset(input logic [1:0] kind, input int n);
        @(posedge clk);
        {rst, wdt_rst} <= kind;
        repeat (n) @(posedge clk);
        #1 chk("restart", 12'h1, 12'(restart));
        chk("reset vector", VEC_RESET, vec);
        @(posedge clk);
        {rst, wdt_rst} <= 2'b00;
        @(posedge clk);
        #1 chk("restart off", 12'h0, 12'(restart));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        hit_reset(2'b10, 4);
        foreach (adl[i])
            rd(adl[i], 4'h0, "reset value");
        wr(ADDR_CNT_LO, 4'h3);
        rd(ADDR_CNT_HI, 4'h0, "count high");
        rd(ADDR_CNT_LO, 4'h0, "count low");
        wr(ADDR_CNT_HI, 4'h5);
        rd(ADDR_CNT_HI, 4'h5, "count high");
        rd(ADDR_CNT_LO, 4'h3, "count low");
        wr(ADDR_DIR_A, 4'hf);
        wr(ADDR_PA, 4'ha);
        wr(ADDR_PULL_A, 4'hf);
        rd(ADDR_PA, 4'ha, "latch read");
        chk("pad oe", 12'h7, 12'(p_oe[3:0]));
        chk("pad out", 12'h2, 12'(p_out[3:0]));
        chk("pullup out", 12'h0, 12'(p_pull));
        wr(ADDR_DIR_A, 4'h0);
        @(posedge clk);
        ext_en <= 6'h38;
        ext_val <= 6'h08;
        repeat (4) @(posedge clk);
        rd(ADDR_PA, 4'hf, "pad read");
        chk("pullup in", 12'h7, 12'(p_pull));
        rd(ADDR_PULL_A, 4'h7, "pull bits");
        @(posedge clk);
        ana <= 4'h1;
        @(posedge clk);
        #1 chk("analog pull", 12'h6, 12'(p_pull));
        wr(ADDR_DIR_B, 4'hf);
        rd(ADDR_DIR_B, 4'h3, "dir b bits");
        wr(ADDR_IRQ_EN, 4'h1);
        @(posedge clk);
        ext_val <= 6'h00;
        repeat (6) @(posedge clk);
        #1 chk("wake stop", 12'h1, 12'(w_stop));
        chk("wake halt", 12'h1, 12'(w_halt));
        pulse_instr(1);
        wr(ADDR_IRQ_EN, 4'h0);
        pulse_instr(2);
        chk("cancelled", 12'h0, 12'(takes));
        wr(ADDR_IRQ_EN, 4'h1);
        pulse_instr(2);
        chk("port vector", VEC_PIN, last_vec);
        rd(ADDR_IRQ_EN, 4'h0, "enables cleared");
        rd(ADDR_IRQ_REQ, 4'h1, "request kept");
        wr(ADDR_IRQ_REQ, 4'h0);
        for (int m = 0; m < 16; m++)
        begin
            wr(ADDR_MODE, 4'(m));
            rd(ADDR_MODE, 4'(m) & MODE_IMPL, "mode bits");
        end
        wr(ADDR_CNT_LO, 4'he);
        wr(ADDR_CNT_HI, 4'hf);
        repeat (8) @(posedge clk);
        rd(ADDR_IRQ_REQ, 4'h4, "timer request");
        rd(ADDR_CNT_HI, 4'hf, "reload high");
        wr(ADDR_IRQ_EN, 4'hd);
        @(posedge clk);
        conv <= 1'b1;
        @(posedge clk);
        conv <= 1'b0;
        #1 chk("halt only", 12'h2, 12'({w_halt, w_stop}));
        pulse_instr(2);
        chk("first vector", VEC_CONV, last_vec);
        rd(ADDR_IRQ_REQ, 4'hc, "requests kept");
        hit_reset(2'b01, 2);
        rd(ADDR_MODE, 4'h7, "mode kept");
        rd(ADDR_IRQ_REQ, 4'h0, "flags cleared");
        rd(ADDR_DIR_A, 4'h0, "dir cleared");
        hit_reset(2'b10, 2);
        rd(ADDR_MODE, 4'h0, "mode cleared");
        wrap_up();
    end
endmodule // tb
`default_nettype wire
